/* shared/instr_decoder_map.vh */
// Purpose: Constants for the fourteen-bit instruction decoder
// Assumes: 14-bit instruction words, 8-bit data path
// Notes:   Field positions, opcode codes, flag bit positions, timing
`ifndef INSTR_DECODER_MAP_VH
`define INSTR_DECODER_MAP_VH

// ****************************************
// Word layout
// ****************************************
`define IW_WIDTH        14
`define IW_PREFIX_HI    13
`define IW_PREFIX_LO    12
`define IW_OP_HI        11
`define IW_OP_LO        8
`define IW_DEST_BIT     7
`define IW_BITSEL_HI    9
`define IW_BITSEL_LO    7
`define IW_FILE_HI      6
`define IW_FILE_LO      0
`define IW_LIT_HI       7
`define IW_LIT_LO       0
`define IW_TARGET_HI    10
`define IW_TARGET_LO    0
`define IW_JUMP_BIT     11

// ****************************************
// Prefixes and opcodes
// ****************************************
`define PFX_BYTE        2'h0
`define PFX_BIT         2'h1
`define PFX_JUMP        2'h2
`define PFX_LIT         2'h3
`define OP_MOVWF        4'h0
`define OP_CLR          4'h1
`define OP_SUB          4'h2
`define OP_DEC          4'h3
`define OP_OR           4'h4
`define OP_AND          4'h5
`define OP_XOR          4'h6
`define OP_ADD          4'h7
`define OP_MOVF         4'h8
`define OP_COM          4'h9
`define OP_INC          4'hA
`define OP_DEC_SKIP     4'hB
`define OP_ROT_RIGHT    4'hC
`define OP_ROT_LEFT     4'hD
`define OP_SWAP         4'hE
`define OP_INC_SKIP     4'hF
`define BOP_CLEAR       2'h0
`define BOP_SET         2'h1
`define BOP_TEST_CLEAR  2'h2
`define BOP_TEST_SET    2'h3
`define WORD_STANDBY    14'h0063
`define WORD_WDT_CLEAR  14'h0064
`define WORD_RETURN     14'h0008
`define WORD_RET_INT    14'h0009

// ****************************************
// Flags and special files
// ****************************************
`define FLAG_C          0
`define FLAG_DC         1
`define FLAG_Z          2
`define FLAG_SLEEP      3
`define FLAG_WDT        4
`define FILE_TIMER0     7'h01
`define FILE_STATUS     7'h03
`define PHASES          4
`define RESET_FLAGS     8'h18

`endif

/* hw/phase_counter.v */
// Purpose: Four-phase sequencer for one instruction cycle
// Assumes: One phase per clock
// Notes:   Phase 0 decode, 1 read, 2 process, 3 write
`timescale 1ns/1ps
`include "instr_decoder_map.vh"
module phase_counter (
	input  wire       i_clk,
	input  wire       i_resetn,
	output reg  [1:0] o_phase
);
	// ****************************************
	// Phase counter
	// ****************************************
	// Free running; wraps after the write phase
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_phase <= 2'h0;
		end else begin
			o_phase <= o_phase + 2'h1;
		end
	end
endmodule

/* hw/fourteen_bit_instr_decoder.v */
// Purpose: Decode and execute 14-bit instruction words
// Assumes: Program memory holds i_instr steady for a full instruction cycle
// Notes:   File memory sits outside; this block reads and writes it by port
//
// Function
// - Accept 14-bit words, 3-6 bit opcodes, 35 instructions
// - xor_reg_op: W xor file, Z only
// - or_reg_op: W or file, Z only
// - rotate_left_carry through carry, C only
// - rotate_right_carry through carry, C only
// - dec_skip_zero: skip on zero, no flags
// - inc_skip_zero: skip on zero, no flags
// - bit_test_skip_clear skips when bit clear
// - bit_test_skip_set skips when bit set
// - or_literal_op into W, Z only
// - xor_literal_op into W, Z only
// - literal_minus_acc sets C, DC, Z
// - return_with_literal loads W, returns, two cycles
// - Standby word clears sleep flag and sets watchdog flag
// - Program counter change or skip adds idle_cycle
// - Port read-modify-write uses pin levels
// - Timer zero write clears assigned prescaler
// - Four phases: decode, read, process, write
// - Flag-affecting status write keeps ALU flags
`timescale 1ns/1ps
`include "instr_decoder_map.vh"
module fourteen_bit_instr_decoder #(
	parameter PC_WIDTH    = 13,
	parameter STACK_DEPTH = 8
) (
	input  wire                 i_clk,
	input  wire                 i_resetn,
	input  wire [13:0]          i_instr,
	input  wire [7:0]           i_file_rdata,
	input  wire                 i_file_is_port,
	input  wire [7:0]           i_port_pins,
	input  wire                 i_prescaler_to_timer,
	input  wire                 i_wdt_timeout,
	output reg  [PC_WIDTH-1:0]  o_pc,
	output reg  [6:0]           o_file_addr,
	output reg  [7:0]           o_file_wdata,
	output reg                  o_file_we,
	output reg  [7:0]           o_acc,
	output reg  [7:0]           o_flags,
	output reg                  o_prescaler_clear,
	output reg                  o_standby,
	output reg                  o_idle_cycle,
	output reg  [1:0]           o_phase
);
	// ****************************************
	// Phase sequencer
	// ****************************************
	wire [1:0] phase;

	phase_counter u_phase (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.o_phase  (phase)
	);

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Pins come from outside; two flops before any use
	reg [7:0] pins_meta_reg;
	reg [7:0] pins_sync_reg;
	reg       wdt_meta_reg;
	reg       wdt_sync_reg;

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pins_meta_reg <= 8'h00;
			pins_sync_reg <= 8'h00;
			wdt_meta_reg  <= 1'b0;
			wdt_sync_reg  <= 1'b0;
		end else begin
			pins_meta_reg <= i_port_pins;
			pins_sync_reg <= pins_meta_reg;
			wdt_meta_reg  <= i_wdt_timeout;
			wdt_sync_reg  <= wdt_meta_reg;
		end
	end

	// ****************************************
	// Field extraction
	// ****************************************
	wire [1:0]          prefix  = i_instr[`IW_PREFIX_HI:`IW_PREFIX_LO];
	wire [3:0]          opcode  = i_instr[`IW_OP_HI:`IW_OP_LO];
	wire                dest_f  = i_instr[`IW_DEST_BIT];
	wire [2:0]          bit_sel = i_instr[`IW_BITSEL_HI:`IW_BITSEL_LO];
	wire [6:0]          faddr   = i_instr[`IW_FILE_HI:`IW_FILE_LO];
	wire [7:0]          literal = i_instr[`IW_LIT_HI:`IW_LIT_LO];
	wire [10:0]         target  = i_instr[`IW_TARGET_HI:`IW_TARGET_LO];

	// Port operands come from the pins, not the output latch
	wire [7:0] operand = i_file_is_port ? pins_sync_reg : i_file_rdata;

	// ****************************************
	// Operand and stack registers
	// ****************************************
	reg [7:0]          opnd_reg;
	reg                skip_reg;
	reg                idle_reg;
	reg [PC_WIDTH-1:0] stack_mem [0:STACK_DEPTH-1];
	reg [2:0]          sp_reg;

	// ****************************************
	// Execute combinational
	// ****************************************
	reg [7:0] result;
	reg [8:0] wide;
	reg [4:0] nib;
	reg       wr_acc;
	reg       wr_file;
	reg       upd_z;
	reg       upd_c;
	reg       upd_dc;
	reg       new_c;
	reg       new_dc;
	reg       take_skip;
	reg       is_call;
	reg       is_jump;
	reg       is_ret;
	reg       is_sleep;
	reg       is_wdtc;

	// One decode per instruction; results used at the write phase
	always @* begin
		result    = 8'h00;
		wide      = 9'h000;
		nib       = 5'h00;
		wr_acc    = 1'b0;
		wr_file   = 1'b0;
		upd_z     = 1'b0;
		upd_c     = 1'b0;
		upd_dc    = 1'b0;
		new_c     = o_flags[`FLAG_C];
		new_dc    = o_flags[`FLAG_DC];
		take_skip = 1'b0;
		is_call   = 1'b0;
		is_jump   = 1'b0;
		is_ret    = 1'b0;
		is_sleep  = 1'b0;
		is_wdtc   = 1'b0;
		case (prefix)
			`PFX_BYTE: begin
				wr_acc  = ~dest_f;
				wr_file = dest_f;
				case (opcode)
					`OP_MOVWF: begin
						if (dest_f) begin
							result = o_acc;
						end else begin
							wr_acc = 1'b0;
							is_sleep = (i_instr == `WORD_STANDBY);
							is_wdtc  = (i_instr == `WORD_WDT_CLEAR);
							is_ret   = (i_instr == `WORD_RETURN) || (i_instr == `WORD_RET_INT);
						end
					end
					`OP_CLR: begin
						result = 8'h00;
						upd_z  = 1'b1;
					end
					`OP_SUB, `OP_ADD: begin
						wide   = (opcode == `OP_ADD) ? ({1'b0, opnd_reg} + {1'b0, o_acc})
						                             : ({1'b0, opnd_reg} + {1'b0, ~o_acc} + 9'h001);
						nib    = (opcode == `OP_ADD) ? ({1'b0, opnd_reg[3:0]} + {1'b0, o_acc[3:0]})
						                             : ({1'b0, opnd_reg[3:0]} + {1'b0, ~o_acc[3:0]} + 5'h01);
						result = wide[7:0];
						new_c  = wide[8];
						new_dc = nib[4];
						upd_z  = 1'b1;
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					`OP_DEC:       begin result = opnd_reg - 8'h01; upd_z = 1'b1; end
					`OP_OR:        begin result = opnd_reg | o_acc; upd_z = 1'b1; end
					`OP_AND:       begin result = opnd_reg & o_acc; upd_z = 1'b1; end
					`OP_XOR:       begin result = opnd_reg ^ o_acc; upd_z = 1'b1; end
					`OP_MOVF:      begin result = opnd_reg;         upd_z = 1'b1; end
					`OP_COM:       begin result = ~opnd_reg;        upd_z = 1'b1; end
					`OP_INC:       begin result = opnd_reg + 8'h01; upd_z = 1'b1; end
					`OP_DEC_SKIP: begin
						result    = opnd_reg - 8'h01;
						take_skip = (result == 8'h00);
					end
					`OP_INC_SKIP: begin
						result    = opnd_reg + 8'h01;
						take_skip = (result == 8'h00);
					end
					`OP_ROT_LEFT: begin
						result = {opnd_reg[6:0], o_flags[`FLAG_C]};
						new_c  = opnd_reg[7];
						upd_c  = 1'b1;
					end
					`OP_ROT_RIGHT: begin
						result = {o_flags[`FLAG_C], opnd_reg[7:1]};
						new_c  = opnd_reg[0];
						upd_c  = 1'b1;
					end
					default: result = {opnd_reg[3:0], opnd_reg[7:4]};
				endcase
			end
			`PFX_BIT: begin
				case (opcode[3:2])
					`BOP_CLEAR: begin
						result  = opnd_reg & ~(8'h01 << bit_sel);
						wr_file = 1'b1;
					end
					`BOP_SET: begin
						result  = opnd_reg | (8'h01 << bit_sel);
						wr_file = 1'b1;
					end
					`BOP_TEST_CLEAR: take_skip = ~opnd_reg[bit_sel];
					default:         take_skip = opnd_reg[bit_sel];
				endcase
			end
			`PFX_JUMP: begin
				is_call = ~i_instr[`IW_JUMP_BIT];
				is_jump = i_instr[`IW_JUMP_BIT];
			end
			default: begin
				wr_acc = 1'b1;
				casez (opcode)
					4'b00??: result = literal;
					4'b01??: begin
						result = literal;
						is_ret = 1'b1;
					end
					4'b1000: begin result = literal | o_acc; upd_z = 1'b1; end
					4'b1001: begin result = literal & o_acc; upd_z = 1'b1; end
					4'b1010: begin result = literal ^ o_acc; upd_z = 1'b1; end
					4'b110?, 4'b111?: begin
						wide   = opcode[1] ? ({1'b0, literal} + {1'b0, o_acc})
						                   : ({1'b0, literal} + {1'b0, ~o_acc} + 9'h001);
						nib    = opcode[1] ? ({1'b0, literal[3:0]} + {1'b0, o_acc[3:0]})
						                   : ({1'b0, literal[3:0]} + {1'b0, ~o_acc[3:0]} + 5'h01);
						result = wide[7:0];
						new_c  = wide[8];
						new_dc = nib[4];
						upd_z  = 1'b1;
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					default: wr_acc = 1'b0;
				endcase
			end
		endcase
	end

	wire changes_pc = is_call | is_jump | is_ret | take_skip;
	wire to_status  = wr_file && (faddr == `FILE_STATUS);
	wire alu_flags  = upd_z | upd_c | upd_dc;

	// ****************************************
	// Sequencer and state
	// ****************************************
	// Work happens on phase 3; an idle cycle suppresses all effects except stepping the counter past a skipped word
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pc              <= {PC_WIDTH{1'b0}};
			o_file_addr       <= 7'h00;
			o_file_wdata      <= 8'h00;
			o_file_we         <= 1'b0;
			o_acc             <= 8'h00;
			o_flags           <= `RESET_FLAGS;
			o_prescaler_clear <= 1'b0;
			o_standby         <= 1'b0;
			o_idle_cycle      <= 1'b0;
			o_phase           <= 2'h0;
			opnd_reg          <= 8'h00;
			idle_reg          <= 1'b0;
			skip_reg          <= 1'b0;
			sp_reg            <= 3'h0;
		end else begin
			o_phase           <= phase;
			o_file_we         <= 1'b0;
			o_prescaler_clear <= 1'b0;
			o_idle_cycle      <= idle_reg;
			if (wdt_sync_reg) begin
				o_flags[`FLAG_WDT] <= 1'b0;
			end
			case (phase)
				2'h0: o_file_addr <= faddr;
				2'h1: opnd_reg <= operand;
				2'h2: ; // Process phase: the decode settles on the held word
				default: begin
					idle_reg <= 1'b0;
					skip_reg <= 1'b0;
					if (!idle_reg && !o_standby) begin
						o_pc <= o_pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
						if (wr_acc) begin
							o_acc <= result;
						end
						if (wr_file && !(to_status && alu_flags)) begin
							o_file_we    <= 1'b1;
							o_file_wdata <= result;
						end
						// Status as target of a flag op: ALU flags win
						if (to_status && !alu_flags) begin
							o_flags[2:0] <= result[2:0];
						end
						if (upd_z) o_flags[`FLAG_Z] <= (result == 8'h00);
						if (upd_c) o_flags[`FLAG_C] <= new_c;
						if (upd_dc) o_flags[`FLAG_DC] <= new_dc;
						if (wr_file && faddr == `FILE_TIMER0 && i_prescaler_to_timer) begin
							o_prescaler_clear <= 1'b1;
						end
						if (is_sleep) begin
							o_flags[`FLAG_SLEEP] <= 1'b0;
							o_flags[`FLAG_WDT]   <= 1'b1;
							o_standby            <= 1'b1;
						end
						if (is_wdtc) begin
							o_flags[`FLAG_SLEEP] <= 1'b1;
							o_flags[`FLAG_WDT]   <= 1'b1;
						end
						if (is_call) begin
							stack_mem[sp_reg] <= o_pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
							sp_reg <= sp_reg + 3'h1;
						end
						if (is_call | is_jump) begin
							o_pc <= {{(PC_WIDTH-11){1'b0}}, target};
						end
						if (is_ret) begin
							o_pc   <= stack_mem[sp_reg - 3'h1];
							sp_reg <= sp_reg - 3'h1;
						end
						idle_reg <= changes_pc;
						skip_reg <= take_skip;
					end else if (idle_reg && skip_reg) begin
						// Step past the skipped word; a loaded counter already points at its target
						o_pc <= o_pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
					end
					if (o_standby && wdt_sync_reg) begin
						o_standby <= 1'b0;
					end
				end
			endcase
		end
	end
endmodule

/* testbench/instr_memory_model.sv */
// Purpose: Program and file memory on the far side of the decoder
// Assumes: Reads are combinational on the addresses the decoder drives
// Notes:   Bench fills both arrays by hierarchical access before reset ends
`timescale 1ns/1ps
module instr_memory_model #(
	parameter PORT_ADDR = 7'h06
) (
	input  wire         i_clk,
	input  wire  [12:0] i_pc,
	input  wire  [6:0]  i_file_addr,
	input  wire  [7:0]  i_file_wdata,
	input  wire         i_file_we,
	output logic [13:0] o_instr,
	output logic [7:0]  o_file_rdata,
	output logic        o_file_is_port
);
	// ****************************************
	// Storage
	// ****************************************
	logic [13:0] prog_mem [0:511];
	logic [7:0]  file_mem [0:127];

	// Words past the array read as idle words, so a runaway counter stays harmless
	assign o_instr = (i_pc < 13'h0200) ? prog_mem[i_pc[8:0]] : 14'h0000;
	assign o_file_rdata = file_mem[i_file_addr];
	assign o_file_is_port = (i_file_addr == PORT_ADDR);

	// Write-back of results
	always @(posedge i_clk) begin
		if (i_file_we)
			file_mem[i_file_addr] <= i_file_wdata;
	end
endmodule

/* testbench/fourteen_bit_instr_decoder_checker.sv */
// Purpose: Port-level assertions for the instruction decoder
// Assumes: Program words stay put for a whole four-phase cycle
// Notes:   Flag checks look at the word of the previous clock
`timescale 1ns/1ps
module fourteen_bit_instr_decoder_checker #(
	parameter PC_WIDTH = 13
) (
	input wire                i_clk,
	input wire                i_resetn,
	input wire [13:0]         i_instr,
	input wire                i_prescaler_to_timer,
	input wire                i_wdt_timeout,
	input wire [PC_WIDTH-1:0] o_pc,
	input wire [6:0]          o_file_addr,
	input wire                o_file_we,
	input wire [7:0]          o_acc,
	input wire [7:0]          o_flags,
	input wire                o_prescaler_clear,
	input wire                o_standby,
	input wire                o_idle_cycle,
	input wire [1:0]          o_phase
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	phase_step_a: assert property ($past(i_resetn, 3) |-> o_phase == $past(o_phase) + 2'h1)
		else $error("phase did not advance by one");
	rot_flags_a: assert property ($past(i_instr[13:9]) == 5'h06 |-> o_flags[7:1] == $past(o_flags[7:1]))
		else $error("rotate touched a flag other than carry");
	skip_flags_a: assert property ($past(i_instr[13:8]) inside {6'h0B, 6'h0F} |-> $stable(o_flags))
		else $error("counting skip changed flags");
	lit_flags_a: assert property ($past(i_instr[13:8]) inside {6'h38, 6'h3A} |->
		{o_flags[7:3], o_flags[1:0]} == {$past(o_flags[7:3]), $past(o_flags[1:0])})
		else $error("literal logic op changed a flag other than zero");
	psc_pulse_a: assert property (o_prescaler_clear |=> !o_prescaler_clear)
		else $error("prescaler clear longer than one clock");
	psc_cause_a: assert property (o_prescaler_clear |-> $past(i_prescaler_to_timer)
		&& ($past(o_file_addr) == 7'h01 || $past(o_file_addr, 2) == 7'h01))
		else $error("prescaler clear without timer write");
	standby_flags_a: assert property ($rose(o_standby) |-> ##[0:4] o_flags[4:3] == 2'h2)
		else $error("standby entry flags wrong");
	standby_hold_a: assert property (o_standby && !i_wdt_timeout |=> $stable(o_pc))
		else $error("counter moved in standby");
	idle_len_a: assert property ($rose(o_idle_cycle) |-> o_idle_cycle[*4] ##1 !o_idle_cycle)
		else $error("idle cycle not four clocks");
	idle_quiet_a: assert property (o_idle_cycle && $past(o_idle_cycle) |-> $stable(o_acc))
		else $error("idle cycle changed the working register");

	// Main scenarios reached
	cover property ($rose(o_idle_cycle));
	cover property ($rose(o_standby));
	cover property (o_prescaler_clear);
	cover property (o_file_we);
endmodule

bind fourteen_bit_instr_decoder fourteen_bit_instr_decoder_checker #(.PC_WIDTH(PC_WIDTH)) i_checker (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_instr(i_instr), .i_prescaler_to_timer(i_prescaler_to_timer),
	.i_wdt_timeout(i_wdt_timeout), .o_pc(o_pc), .o_file_addr(o_file_addr), .o_file_we(o_file_we),
	.o_acc(o_acc), .o_flags(o_flags), .o_prescaler_clear(o_prescaler_clear), .o_standby(o_standby),
	.o_idle_cycle(o_idle_cycle), .o_phase(o_phase));

/* testbench/fourteen_bit_instr_decoder_test.sv */
// Purpose: Self-checking bench for the instruction decoder
// Assumes: A reference walk of the program predicts every file write
// Notes:   Trap words behind skips write W to file 0x7F if wrongly executed
`timescale 1ns/1ps
module fourteen_bit_instr_decoder_test;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
		logic [2:0] flags;
	} wr_t;
	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic [7:0]  i_port_pins = 8'h00;
	logic        i_prescaler_to_timer = 1'b1;
	logic        i_wdt_timeout = 1'b0;
	wire  [13:0] i_instr;
	wire  [7:0]  i_file_rdata, o_file_wdata, o_acc, o_flags;
	wire         i_file_is_port, o_file_we, o_prescaler_clear, o_standby, o_idle_cycle;
	wire  [12:0] o_pc;
	wire  [6:0]  o_file_addr;
	wire  [1:0]  o_phase;
	int          err_count = 0, tests_run = 0, pc_w = 0, psc_exp = 0, psc_seen = 0;
	logic [7:0]  r_acc = 8'h00, pins_v, r_fm [0:127];
	logic        r_c = 1'b0, r_dc = 1'b0, r_z = 1'b0, skip_next = 1'b0, psc_on = 1'b1;
	wr_t         exp_q [$];

	fourteen_bit_instr_decoder i_fourteen_bit_instr_decoder (.i_clk(i_clk), .i_resetn(i_resetn), .i_instr(i_instr),
		.i_file_rdata(i_file_rdata), .i_file_is_port(i_file_is_port), .i_port_pins(i_port_pins),
		.i_prescaler_to_timer(i_prescaler_to_timer), .i_wdt_timeout(i_wdt_timeout), .o_pc(o_pc),
		.o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata), .o_file_we(o_file_we), .o_acc(o_acc),
		.o_flags(o_flags), .o_prescaler_clear(o_prescaler_clear), .o_standby(o_standby),
		.o_idle_cycle(o_idle_cycle), .o_phase(o_phase));
	instr_memory_model i_instr_memory_model (.i_clk(i_clk), .i_pc(o_pc), .i_file_addr(o_file_addr),
		.i_file_wdata(o_file_wdata), .i_file_we(o_file_we), .o_instr(i_instr), .o_file_rdata(i_file_rdata),
		.o_file_is_port(i_file_is_port));

	always #50 i_clk = ~i_clk;

	// ****************************************
	// Checking and reference
	// ****************************************
	task automatic chk_val(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_write(input wr_t exp, input wr_t got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR file write expected %h seen %h", exp, got);
		end
	endtask

	task automatic print_verdict;
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Places a word and walks its effect; a skipped word is placed but not walked
	task automatic emit(input logic [13:0] w);
		logic [7:0] f;
		logic [7:0] r;
		logic [8:0] s;
		i_instr_memory_model.prog_mem[pc_w] = w;
		pc_w++;
		if (skip_next) begin
			skip_next = 1'b0;
			return;
		end
		f = (w[6:0] == 7'h06) ? pins_v : r_fm[w[6:0]];
		s = {1'b0, w[7:0]} - {1'b0, r_acc};
		r = f;
		if (w[13:12] == 2'h1)
			skip_next = w[10] ~^ f[w[9:7]];
		if (w[13:12] == 2'h3) begin
			case (w[11:8])
				4'h4, 4'h5, 4'h6, 4'h7: r_acc = w[7:0];
				4'h8: r_acc = r_acc | w[7:0];
				4'hA: r_acc = r_acc ^ w[7:0];
				4'hC, 4'hD: begin
					r_c = ~s[8];
					r_dc = (w[3:0] >= r_acc[3:0]);
					r_acc = s[7:0];
				end
				default: ;
			endcase
			if (w[11:8] inside {4'h8, 4'hA, 4'hC, 4'hD})
				r_z = (r_acc == 8'h00);
		end
		if (w[13:12] == 2'h0) begin
			case (w[11:8])
				4'h0: r = r_acc;
				4'h4: r = r_acc | f;
				4'h6: r = r_acc ^ f;
				4'hB: r = f - 8'h01;
				4'hF: r = f + 8'h01;
				4'hC: r = {r_c, f[7:1]};
				4'hD: r = {f[6:0], r_c};
				default: ;
			endcase
			if (w[11:8] inside {4'h4, 4'h6, 4'h8})
				r_z = (r == 8'h00);
			if (w[11:8] inside {4'hB, 4'hF})
				skip_next = (r == 8'h00);
			if (w[11:9] == 3'h6)
				r_c = w[8] ? f[7] : f[0];
			if (!w[7])
				r_acc = r;
			else begin
				r_fm[w[6:0]] = r;
				exp_q.push_back({w[6:0], r, r_z, r_dc, r_c});
				if (w[6:0] == 7'h01 && psc_on)
					psc_exp++;
			end
		end
	endtask

	// Trap word behind every conditional skip
	task automatic emit_trap(input logic [13:0] w);
		emit(w);
		emit(14'h00FF);
	endtask

	task automatic wait_standby(input logic lvl);
		for (int n = 0; n < 3000 && o_standby !== lvl; n++)
			@(posedge i_clk);
		#1;
		if (o_standby !== lvl) begin
			err_count++;
			$display("ERROR standby expected %b seen %b", lvl, o_standby);
			print_verdict();
		end
	endtask

	// Each file write takes the oldest predicted write off the queue
	always @(posedge i_clk) begin
		if (i_resetn && o_file_we && exp_q.size() == 0) begin
			err_count++;
			$display("ERROR file write expected none seen %h", o_file_addr);
		end else if (i_resetn && o_file_we)
			chk_write(exp_q.pop_front(), {o_file_addr, o_file_wdata, o_flags[2:0]});
		if (i_resetn && o_prescaler_clear)
			psc_seen++;
	end

	// ****************************************
	// Program and sequence
	// ****************************************
	initial begin
		void'($urandom(32'h20ba));
		pins_v = 8'($urandom);
		for (int a = 0; a < 512; a++)
			i_instr_memory_model.prog_mem[a] = 14'h0000;
		for (int a = 0; a < 128; a++) begin
			r_fm[a] = (a == 16) ? 8'h01 : (a == 17) ? 8'hFF : 8'($urandom);
			i_instr_memory_model.file_mem[a] = r_fm[a];
		end
		emit({6'h38, 8'($urandom)});
		emit({6'h06, 1'b1, 7'h20});
		emit({6'h04, 1'b0, 7'h21});
		emit({6'h00, 1'b1, 7'h22});
		emit({6'h0D, 1'b1, 7'h23});
		emit({6'h0C, 1'b1, 7'h24});
		for (int i = 0; i < 4; i++) begin
			emit_trap({6'h0B, 1'b1, 7'h10 + 7'(i)});
			emit_trap({6'h0F, 1'b1, 7'h11 + 7'(i)});
			emit_trap({2'h1, 1'b1, i[0], 3'($urandom), 7'h25});
		end
		for (int i = 0; i < 3; i++) begin
			emit({6'h3A, 8'($urandom)});
			emit({5'h1E, i[0], (i == 2) ? r_acc : 8'($urandom)});
			emit({6'h00, 1'b1, 7'h26 + 7'(i)});
		end
		emit({3'h5, 11'(pc_w + 2)});
		skip_next = 1'b1;
		emit(14'h00FF);
		emit({3'h4, 11'h100});
		i_instr_memory_model.prog_mem[256] = {6'h34, 8'h5A};
		r_acc = 8'h5A;
		emit({6'h00, 1'b1, 7'h2A});
		emit({6'h06, 1'b1, 7'h01});
		emit({6'h06, 1'b0, 7'h01});
		emit({6'h08, 1'b1, 7'h06});
		emit(14'h0063);
		// Timer write after wake, with the prescaler handed to the watchdog: no clear
		psc_on = 1'b0;
		emit({6'h06, 1'b1, 7'h01});
		@(posedge i_clk);
		i_port_pins <= pins_v;
		repeat (10) @(posedge i_clk);
		i_resetn <= 1'b1;
		wait_standby(1'b1);
		chk_val("sleep flags", 8'h02, {6'h00, o_flags[4:3]});
		chk_val("prescaler clears", 8'(psc_exp), 8'(psc_seen));
		@(posedge i_clk);
		i_wdt_timeout <= 1'b1;
		i_prescaler_to_timer <= 1'b0;
		repeat (8) @(posedge i_clk);
		i_wdt_timeout <= 1'b0;
		wait_standby(1'b0);
		repeat (8) @(posedge i_clk);
		#1;
		chk_val("expiry flag", 8'h00, {7'h00, o_flags[4]});
		chk_val("acc", r_acc, o_acc);
		chk_val("flags", {5'h00, r_z, r_dc, r_c}, {5'h00, o_flags[2:0]});
		chk_val("writes left", 8'h00, 8'(exp_q.size()));
		chk_val("prescaler clears", 8'(psc_exp), 8'(psc_seen));
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk_val("reset flags", 8'h18, o_flags);
		chk_val("reset acc", 8'h00, o_acc);
		print_verdict();
	end

	// Hang guard
	initial begin
		repeat (50000) @(posedge i_clk);
		err_count++;
		print_verdict();
	end
endmodule
